/* File: core/clk_loop_pkg.sv */
`default_nettype none
package clk_loop_pkg;
  // spi frame: read flag, 15-bit address, 8-bit data, msb first
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS   = 16;
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;

  // register offsets
  localparam logic [14:0] NOISE_OFF = 15'h002b;
  localparam logic [14:0] RREN_OFF  = 15'h002c;
  localparam logic [14:0] TRIG_OFF  = 15'h002d;
  localparam logic [14:0] DIV_OFF   = 15'h003d;
  localparam logic [14:0] FB_OFF    = 15'h003e;
  localparam logic [14:0] HOLD_OFF  = 15'h005c;
  localparam logic [14:0] ARM_OFF   = 15'h005d;
  localparam logic [14:0] DONE_OFF  = 15'h005e;
  localparam logic [14:0] LOCK_OFF  = 15'h0208;

  // field positions
  localparam int DIV_P_LSB     = 0;
  localparam int DIV_V_LSB     = 4;
  localparam int NOISE_ANA_BIT = 0;
  localparam int NOISE_CLK_BIT = 1;
  localparam int TRIG_EN_BIT   = 0;
  localparam int TRIG_MODE_LSB = 1;
  localparam int TRIG_DIV_LSB  = 4;
  localparam logic [1:0] TRIG_MODE_TS = 2'h3;

  // reset values
  localparam logic [7:0] NOISE_RST = 8'h00;
  localparam logic [7:0] RREN_RST  = 8'h01;
  localparam logic [7:0] TRIG_RST  = 8'h00;
  localparam logic [7:0] DIV_RST   = 8'h00;
  localparam logic [7:0] FB_RST    = 8'h00;
  localparam logic [7:0] HOLD_RST  = 8'h01;
  localparam logic [7:0] ARM_RST   = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CAL_TIME_NS   = 1000;
  localparam int LOCK_TIME_NS  = 400;
  localparam int CAL_CYCLES    =
    (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES   =
    (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF     = 8;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_WAIT, CAL_LOCKED}
    cal_state_t;
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
endpackage
`default_nettype wire

/* File: core/clk_loop_link_if.sv */
`default_nettype none
interface clk_loop_link_if;
  logic sclk;
  logic csn_b;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic loop_enable_pin;
  logic single_ended_ref_select;
  logic power_down_pin;
  logic timestamp_input;
  logic reference_repeat_output;
  logic trigger_clock_output;

  modport device_end (
    input  sclk, csn_b, mosi, loop_enable_pin, single_ended_ref_select,
           power_down_pin, timestamp_input,
    output miso, miso_oe, reference_repeat_output, trigger_clock_output
  );
  modport host_end (
    output sclk, csn_b, mosi, loop_enable_pin, single_ended_ref_select,
           power_down_pin, timestamp_input,
    input  miso, miso_oe, reference_repeat_output, trigger_clock_output
  );
endinterface
`default_nettype wire

/* File: core/loop_ctrl_device.sv */
`default_nettype none
module loop_ctrl_device
  import clk_loop_pkg::*;
#(
  parameter int CAL_CNT  = CAL_CYCLES,
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  clk_loop_link_if.device_end   lk,
  input  wire logic             diff_clock_input,
  input  wire logic             single_ended_clock_input,
  input  wire logic             serializer_loop_clock,
  output logic                  sample_from_synth,
  output logic                  analog_supply_rail_filter,
  output logic                  clock_supply_rail_filter
);
  localparam int NSYNC  = 10;
  localparam int S_SCLK = 0, S_CSN = 1, S_MOSI = 2, S_PLL = 3, S_SEL = 4;
  localparam int S_PD   = 5, S_TS = 6, S_DIFF = 7, S_SE = 8, S_SER = 9;

  logic [NSYNC-1:0] pin_raw, s1_r, s2_r;
  logic             sclk_d_r, ser_d_r, miso_r, miso_oe_r;
  logic [4:0]       bcnt_r;
  logic [23:0]      sh_in_r;
  logic [7:0]       sh_out_r, wr_data;
  logic             rise, fall, wr_stb, hold_fall, hold_set, div_ok;
  logic [14:0]      wr_addr, rd_addr;
  logic [7:0]       noise_r, rren_r, trig_r, div_r, fb_r, hold_r, arm_r;
  logic             done_r, lock_r;
  cal_state_t       cal_r;
  logic [15:0]      cnt_r;
  logic [3:0]       ser_cnt_r;
  logic             ser_div, rr_out_r, trig_out_r, synth_r, ana_r, clkf_r;
  assign pin_raw = {serializer_loop_clock, single_ended_clock_input,
                    diff_clock_input, lk.timestamp_input, lk.power_down_pin,
                    lk.single_ended_ref_select, lk.loop_enable_pin,
                    lk.mosi, lk.csn_b, lk.sclk};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r[i] <= 1'(i == S_CSN); // idle levels, no false frame
        s2_r[i] <= 1'(i == S_CSN);
      end else begin
        s1_r[i] <= pin_raw[i];
        s2_r[i] <= s1_r[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
      ser_d_r  <= 1'b0;
    end else begin
      sclk_d_r <= s2_r[S_SCLK];
      ser_d_r  <= s2_r[S_SER];
    end
  end

  assign rise    = s2_r[S_SCLK] & ~sclk_d_r;
  assign fall    = ~s2_r[S_SCLK] & sclk_d_r;
  assign wr_stb  = ~s2_r[S_CSN] & rise & (bcnt_r == 5'd23) & ~sh_in_r[22];
  assign wr_addr = sh_in_r[21:7];
  assign wr_data = {sh_in_r[6:0], s2_r[S_MOSI]};
  assign rd_addr = {sh_in_r[13:0], s2_r[S_MOSI]};

  function automatic logic [7:0] rd_mux(input logic [14:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == NOISE_OFF) begin
      d = noise_r;
    end else if (a == RREN_OFF) begin
      d = rren_r;
    end else if (a == TRIG_OFF) begin
      d = trig_r;
    end else if (a == DIV_OFF) begin
      d = div_r;
    end else if (a == FB_OFF) begin
      d = fb_r;
    end else if (a == HOLD_OFF) begin
      d = hold_r;
    end else if (a == ARM_OFF) begin
      d = arm_r;
    end else if (a == DONE_OFF) begin
      d = {7'h00, done_r};
    end else if (a == LOCK_OFF) begin
      d = {7'h00, lock_r};
    end
    return d;
  endfunction
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_r    <= 5'd0;
      sh_in_r   <= 24'h000000;
      sh_out_r  <= 8'h00;
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= ~s2_r[S_CSN];
      if (s2_r[S_CSN]) begin
        bcnt_r <= 5'd0;
      end else if (rise) begin
        sh_in_r <= {sh_in_r[22:0], s2_r[S_MOSI]};
        if (bcnt_r != 5'd24) begin
          bcnt_r <= bcnt_r + 5'd1;
        end
        if (bcnt_r == 5'd15) begin
          sh_out_r <= rd_mux(rd_addr);
        end
      end else if (fall && bcnt_r >= 5'd16) begin
        miso_r   <= sh_out_r[7];
        sh_out_r <= {sh_out_r[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      noise_r <= NOISE_RST;
      rren_r  <= RREN_RST;
      trig_r  <= TRIG_RST;
      div_r   <= DIV_RST;
      fb_r    <= FB_RST;
      hold_r  <= HOLD_RST;
      arm_r   <= ARM_RST;
    end else if (wr_stb) begin
      if (wr_addr == NOISE_OFF) begin
        noise_r <= wr_data;
      end else if (wr_addr == RREN_OFF) begin
        rren_r <= wr_data;
      end else if (wr_addr == TRIG_OFF) begin
        trig_r <= wr_data;
      end else if (wr_addr == DIV_OFF) begin
        div_r <= wr_data;
      end else if (wr_addr == FB_OFF) begin
        fb_r <= wr_data;
      end else if (wr_addr == HOLD_OFF) begin
        hold_r <= wr_data;
      end else if (wr_addr == ARM_OFF) begin
        arm_r <= wr_data;
      end
    end
  end

  assign hold_fall = wr_stb & (wr_addr == HOLD_OFF) & ~wr_data[0] & hold_r[0];
  assign hold_set  = hold_r[0] | ~s2_r[S_PLL];
  always_comb begin
    logic [7:0] prod;
    prod = 8'(div_r[DIV_P_LSB +: 4] * div_r[DIV_V_LSB +: 4]);
    div_ok = ((prod == 8'h05) || (prod == 8'h06) || (prod == 8'h08) ||
              (prod == 8'h0a) || (prod == 8'h0c) || (prod == 8'h10)) &&
             (fb_r != 8'h00);
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cal_r  <= CAL_IDLE;
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      case (cal_r)
        CAL_IDLE: begin
          lock_r <= 1'b0;
          cnt_r  <= 16'h0000;
          if (hold_fall && s2_r[S_PLL]) begin
            if (arm_r[0]) begin
              done_r <= 1'b0;
              cal_r  <= CAL_RUN;
            end else if (done_r && div_ok) begin
              cal_r <= CAL_WAIT;
            end
          end
        end
        CAL_RUN: begin
          if (hold_set) begin
            cal_r <= CAL_IDLE;
          end else if (cnt_r == 16'(CAL_CNT - 1)) begin
            done_r <= 1'b1;
            cnt_r  <= 16'h0000;
            cal_r  <= div_ok ? CAL_WAIT : CAL_IDLE;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        CAL_WAIT: begin
          if (hold_set) begin
            cal_r <= CAL_IDLE;
          end else if (cnt_r == 16'(LOCK_CNT - 1)) begin
            lock_r <= 1'b1;
            cal_r  <= CAL_LOCKED;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        CAL_LOCKED: begin
          if (hold_set || !div_ok) begin
            lock_r <= 1'b0;
            cal_r  <= CAL_IDLE;
          end
        end
        default: cal_r <= CAL_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ser_cnt_r <= 4'h0;
    end else if (s2_r[S_SER] && !ser_d_r) begin
      if (ser_cnt_r >= trig_r[TRIG_DIV_LSB +: 4] - 4'h1) begin
        ser_cnt_r <= 4'h0;
      end else begin
        ser_cnt_r <= ser_cnt_r + 4'h1;
      end
    end
  end

  assign ser_div = (trig_r[TRIG_DIV_LSB +: 4] <= 4'h1) ? s2_r[S_SER] :
                   (ser_cnt_r < {1'b0, trig_r[TRIG_DIV_LSB + 1 +: 3]});
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rr_out_r   <= 1'b0;
      trig_out_r <= 1'b0;
      synth_r    <= 1'b0;
      ana_r      <= 1'b0;
      clkf_r     <= 1'b0;
    end else begin
      synth_r  <= s2_r[S_PLL];
      ana_r    <= noise_r[NOISE_ANA_BIT];
      clkf_r   <= noise_r[NOISE_CLK_BIT];
      rr_out_r <= s2_r[S_PLL] & ~s2_r[S_PD] & rren_r[0] &
                  (s2_r[S_SEL] ? s2_r[S_SE] : s2_r[S_DIFF]);
      if (!trig_r[TRIG_EN_BIT]) begin
        trig_out_r <= 1'b0;
      end else if (trig_r[TRIG_MODE_LSB +: 2] == TRIG_MODE_TS) begin
        trig_out_r <= s2_r[S_TS];
      end else begin
        trig_out_r <= ser_div;
      end
    end
  end

  assign lk.miso                    = miso_r;
  assign lk.miso_oe                 = miso_oe_r;
  assign lk.reference_repeat_output = rr_out_r;
  assign lk.trigger_clock_output    = trig_out_r;
  assign sample_from_synth          = synth_r;
  assign analog_supply_rail_filter  = ana_r;
  assign clock_supply_rail_filter   = clkf_r;
endmodule
`default_nettype wire

/* File: core/loop_ctrl_host.sv */
`default_nettype none
module loop_ctrl_host
  import clk_loop_pkg::*;
#(
  parameter int HALF = SCLK_HALF
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  clk_loop_link_if.host_end     lk,
  input  wire logic             cmd_valid,
  input  wire logic             cmd_read,
  input  wire logic [14:0]      cmd_addr,
  input  wire logic [7:0]       cmd_wdata,
  output logic                  cmd_ready,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_data,
  input  wire logic             loop_enable_req,
  input  wire logic             ref_select_req,
  input  wire logic             power_down_req,
  input  wire logic             trigger_event,
  output logic                  ref_repeat_seen,
  output logic                  trigger_seen
);
  host_state_t st_r;
  logic [7:0]  hc_r;
  logic [4:0]  bit_r;
  logic [23:0] sh_r;
  logic [7:0]  rx_r;
  logic        sclk_r;
  logic        csn_r;
  logic        mosi_r;
  logic        ready_r;
  logic        rsp_r;
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [3:0]  pins_r;

  // miso and returned clocks are pins: synchronise first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {lk.trigger_clock_output, lk.reference_repeat_output,
               lk.miso & lk.miso_oe};
      s2_r <= s1_r;
    end
  end

  // strap pins, software sets them before configuring
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins_r <= 4'h0;
    end else begin
      pins_r <= {trigger_event, power_down_req, ref_select_req,
                 loop_enable_req};
    end
  end

  // spi master: 24-bit frames, sample on rise, change on fall
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= H_IDLE;
      hc_r    <= 8'h00;
      bit_r   <= 5'd0;
      sh_r    <= 24'h000000;
      rx_r    <= 8'h00;
      sclk_r  <= 1'b0;
      csn_r   <= 1'b1;
      mosi_r  <= 1'b0;
      ready_r <= 1'b0;
      rsp_r   <= 1'b0;
    end else begin
      rsp_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          ready_r <= 1'b1;
          if (cmd_valid && ready_r) begin
            sh_r    <= {cmd_read, cmd_addr, cmd_wdata};
            mosi_r  <= cmd_read;
            csn_r   <= 1'b0;
            hc_r    <= 8'h00;
            bit_r   <= 5'd0;
            ready_r <= 1'b0;
            st_r    <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (hc_r == 8'(HALF - 1)) begin
            hc_r <= 8'h00;
            if (!sclk_r) begin
              sclk_r <= 1'b1;
              rx_r   <= {rx_r[6:0], s2_r[0]};
            end else begin
              sclk_r <= 1'b0;
              if (bit_r == 5'd23) begin
                csn_r <= 1'b1;
                st_r  <= H_GAP;
              end else begin
                bit_r  <= bit_r + 5'd1;
                sh_r   <= {sh_r[22:0], 1'b0};
                mosi_r <= sh_r[22];
              end
            end
          end else begin
            hc_r <= hc_r + 8'h01;
          end
        end
        H_GAP: begin
          if (hc_r == 8'(HALF - 1)) begin
            hc_r  <= 8'h00;
            rsp_r <= 1'b1;
            st_r  <= H_IDLE;
          end else begin
            hc_r <= hc_r + 8'h01;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign lk.sclk                    = sclk_r;
  assign lk.csn_b                   = csn_r;
  assign lk.mosi                    = mosi_r;
  assign lk.loop_enable_pin         = pins_r[0];
  assign lk.single_ended_ref_select = pins_r[1];
  assign lk.power_down_pin          = pins_r[2];
  assign lk.timestamp_input         = pins_r[3];
  assign cmd_ready                  = ready_r;
  assign rsp_valid                  = rsp_r;
  assign rsp_data                   = rx_r;
  assign ref_repeat_seen            = s2_r[1];
  assign trigger_seen               = s2_r[2];
endmodule
`default_nettype wire

/* File: test/clk_loop_chk.sv */
`default_nettype none
module clk_loop_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic csn_b,
  input wire logic miso_oe,
  input wire logic loop_enable_pin,
  input wire logic power_down_pin,
  input wire logic reference_repeat_output,
  input wire logic trigger_clock_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence frame_open;
    $fell(csn_b);
  endsequence
  sequence frame_close;
    ##[370:400] $rose(csn_b);
  endsequence

  oe_idle_a: assert property (csn_b [*5] |-> !miso_oe)
    else $error("miso enable while deselected");
  oe_rise_a: assert property (frame_open |-> ##[1:5] miso_oe)
    else $error("miso enable late");
  sclk_idle_a: assert property (csn_b |-> !sclk)
    else $error("sclk high outside frame");
  sclk_pace_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("sclk half period short");
  frame_len_a: assert property (frame_open |-> frame_close)
    else $error("frame length wrong");
  rr_down_a: assert property (
    power_down_pin [*5] |-> !reference_repeat_output)
    else $error("repeat output active in power down");
  rr_loop_a: assert property (
    !loop_enable_pin [*5] |-> !reference_repeat_output)
    else $error("repeat output active with loop off");
  trig_rst_a: assert property (
    $rose(rst_b) |-> !trigger_clock_output [*8])
    else $error("trigger output active after reset");
endmodule
`default_nettype wire

/* File: test/tb_sampling_clock_loop_control.sv */
`default_nettype none
module tb_sampling_clock_loop_control;
  import clk_loop_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_b, cmd_valid, cmd_read, cmd_ready, rsp_valid;
  logic        le, sel, pwr_dn, trg, rr_seen, trg_seen, synth, fa, fc;
  logic        diff_ck, se_ck, ser_ck;
  logic [14:0] cmd_addr;
  logic [7:0]  cmd_wdata, rsp_data;
  int          failures, n_checks;

  clk_loop_link_if lk();
  always #4 mclk = ~mclk;
  always #32 ser_ck = ~ser_ck;

  loop_ctrl_device #(.CAL_CNT(4), .LOCK_CNT(3)) u_loop_ctrl_device (
    .mclk(mclk), .rst_b(rst_b), .lk(lk),
    .diff_clock_input(diff_ck), .single_ended_clock_input(se_ck),
    .serializer_loop_clock(ser_ck), .sample_from_synth(synth),
    .analog_supply_rail_filter(fa), .clock_supply_rail_filter(fc));
  loop_ctrl_host u_loop_ctrl_host (
    .mclk(mclk), .rst_b(rst_b), .lk(lk), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .loop_enable_req(le), .ref_select_req(sel), .power_down_req(pwr_dn),
    .trigger_event(trg), .ref_repeat_seen(rr_seen),
    .trigger_seen(trg_seen));
  clk_loop_chk u_clk_loop_chk (
    .mclk(mclk), .rst_b(rst_b), .sclk(lk.sclk), .csn_b(lk.csn_b),
    .miso_oe(lk.miso_oe), .loop_enable_pin(lk.loop_enable_pin),
    .power_down_pin(lk.power_down_pin),
    .reference_repeat_output(lk.reference_repeat_output),
    .trigger_clock_output(lk.trigger_clock_output));

  task conclude;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(inout int k);
    k++;
    if (k > 3000) begin
      failures++;
      $display("CHECK FAILED at %0t: no response", $time);
      conclude();
    end else begin
      @(negedge mclk);
    end
  endtask

  task xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) tick(k);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) tick(k);
  endtask

  task rd(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk(rsp_data, e);
  endtask

  task wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task settle;
    repeat (12) @(negedge mclk);
  endtask

  task t_reset;
    rd(NOISE_OFF, NOISE_RST);
    rd(RREN_OFF, RREN_RST);
    rd(TRIG_OFF, TRIG_RST);
    rd(DIV_OFF, DIV_RST);
    rd(FB_OFF, FB_RST);
    rd(HOLD_OFF, HOLD_RST);
    rd(ARM_OFF, ARM_RST);
    rd(DONE_OFF, 8'h00);
    rd(LOCK_OFF, 8'h00);
    rd(15'h0100, 8'h00);
    $display("reset test done");
  endtask

  task t_regs;
    wr(NOISE_OFF, 8'h02);
    settle();
    chk(8'({fc, fa}), 8'h02);
    rd(NOISE_OFF, 8'h02);
    wr(DONE_OFF, 8'hff);
    rd(DONE_OFF, 8'h00);
    wr(15'h0100, 8'h5a);
    rd(15'h0100, 8'h00);
    $display("register test done");
  endtask

  task t_cal;
    logic [7:0] pv[6];
    pv = '{8'h51, 8'h61, 8'h81, 8'ha1, 8'hc1, 8'h82};
    le = 1'b1;
    wr(HOLD_OFF, 8'h01);
    wr(DIV_OFF, 8'h51);
    wr(FB_OFF, 8'h0a);
    rd(DIV_OFF, 8'h51);
    rd(FB_OFF, 8'h0a);
    wr(ARM_OFF, 8'h01);
    rd(DONE_OFF, 8'h00);
    wr(HOLD_OFF, 8'h00);
    rd(DONE_OFF, 8'h01);
    rd(LOCK_OFF, 8'h01);
    chk(8'(synth), 8'h01);
    wr(HOLD_OFF, 8'h01);
    rd(LOCK_OFF, 8'h00);
    foreach (pv[i]) begin
      wr(HOLD_OFF, 8'h01);
      wr(DIV_OFF, pv[i]);
      wr(ARM_OFF, 8'h01);
      wr(HOLD_OFF, 8'h00);
      rd(LOCK_OFF, 8'h01);
    end
    wr(HOLD_OFF, 8'h01);
    wr(DIV_OFF, 8'h71);
    wr(ARM_OFF, 8'h01);
    wr(HOLD_OFF, 8'h00);
    rd(DONE_OFF, 8'h01);
    rd(LOCK_OFF, 8'h00);
    le = 1'b0;
    settle();
    chk(8'(synth), 8'h00);
    le = 1'b1;
    $display("calibration test done");
  endtask

  task t_refrep;
    diff_ck = 1'b1;
    settle();
    chk(8'(rr_seen), 8'h01);
    sel = 1'b1;
    settle();
    chk(8'(rr_seen), 8'h00);
    se_ck = 1'b1;
    settle();
    chk(8'(rr_seen), 8'h01);
    pwr_dn = 1'b1;
    settle();
    chk(8'(rr_seen), 8'h00);
    pwr_dn = 1'b0;
    wr(RREN_OFF, 8'h00);
    settle();
    chk(8'(rr_seen), 8'h00);
    wr(RREN_OFF, 8'h01);
    le = 1'b0;
    settle();
    chk(8'(rr_seen), 8'h00);
    le = 1'b1;
    settle();
    chk(8'(rr_seen), 8'h01);
    $display("reference repeat test done");
  endtask

  task t_trig;
    int c;
    int lo;
    logic p;
    wr(TRIG_OFF, 8'h06);
    trg = 1'b1;
    settle();
    chk(8'(trg_seen), 8'h00);
    wr(TRIG_OFF, 8'h07);
    settle();
    chk(8'(trg_seen), 8'h01);
    trg = 1'b0;
    settle();
    chk(8'(trg_seen), 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(TRIG_OFF, (m == 3) ? 8'h11 : (8'h41 | 8'(m << 1)));
      lo = (m == 3) ? 79 : 19;
      c = 0;
      p = lk.trigger_clock_output;
      repeat (640) begin
        @(negedge mclk);
        if (lk.trigger_clock_output && !p) c++;
        p = lk.trigger_clock_output;
      end
      chk(8'(c >= lo && c <= lo + 2), 8'h01);
    end
    $display("trigger test done");
  endtask

  initial begin
    {rst_b, cmd_valid, cmd_read, le, sel, pwr_dn, trg} = '0;
    {diff_ck, se_ck, ser_ck} = '0;
    cmd_addr = '0;
    cmd_wdata = '0;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_cal();
    t_refrep();
    t_trig();
    conclude();
  end
endmodule
`default_nettype wire
